// ==== verilog/pcibp_agent.sv ====
// Far end of the bus port: one external agent (master and memory
// target) plus the external arbiter used in the two external modes,
// and the request buffer that the device end drains.
// Assumes the same clock as the device end; pins via pcibp_if.
`timescale 1ns/1ps
`default_nettype none
`include "pcibp_cfg.svh"

module pcibp_fifo #(
  parameter int W     = 72,
  parameter int DEPTH = `PCIBP_FIFO_DEPTH
) (
  // Clock and control
  input  wire logic         i_sys_clk,
  input  wire logic         i_rst_n,
  input  wire logic         i_clk_en,
  // Fill side
  input  wire logic         i_in_valid,
  input  wire logic [W-1:0] i_in_data,
  output logic              o_in_ready,
  // Drain side
  output logic              o_out_valid,
  output logic [W-1:0]      o_out_data,
  input  wire logic         i_out_ready
);
  import pcibp_pkg::*;
  // Pointers wrap naturally, so DEPTH must be a power of two
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0]           wp;
    logic [AW-1:0]           rp;
    logic [AW:0]             cnt;
    logic                    rdy;
    logic                    vld;
  } pcibp_fifo_t;
  pcibp_fifo_t q, d;
  logic push, pop;

  always_comb
  begin
    d    = q;
    push = i_in_valid & q.rdy;
    pop  = i_out_ready & q.vld;
    if (push)
    begin
      d.mem[q.wp] = i_in_data;
      d.wp        = q.wp + 1'b1;
    end
    if (pop)
      d.rp = q.rp + 1'b1;
    d.cnt = q.cnt + (AW+1)'(push) - (AW+1)'(pop);
    d.rdy = d.cnt != (AW+1)'(DEPTH);
    d.vld = d.cnt != '0;
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_n)
    begin
      q     <= '0;
      q.rdy <= 1'b1;
    end
    else if (i_clk_en)
      q <= d;
  end

  assign o_in_ready  = q.rdy;
  assign o_out_valid = q.vld;
  assign o_out_data  = q.mem[q.rp];
endmodule

module pcibp_agent #(
  parameter logic [1:0]  P_IDX  = 2'h0,
  parameter logic [31:0] P_BASE = `PCIBP_AGT_BASE,
  parameter logic [31:0] P_MASK = `PCIBP_WIN_MASK
) (
  // Clock and control
  input  wire logic               i_sys_clk,
  input  wire logic               i_rst_n,
  input  wire logic               i_clk_en,
  input  wire pcibp_pkg::pcibp_mode_t i_mode,
  // Master request, held until done
  input  wire logic               i_m_valid,
  input  wire pcibp_pkg::pcibp_req_t i_m_req,
  output logic                    o_m_done,
  output logic                    o_m_abort,
  output logic [31:0]             o_m_rd_data,
  // Target side
  input  wire logic [31:0]        i_t_rd_data,
  output logic                    o_t_wr_valid,
  output logic [31:0]             o_t_wr_data,
  // Bus pins
  pcibp_if.agt                    bus
);
  import pcibp_pkg::*;

  typedef struct packed {
    pcibp_st_t   st;
    pcibp_req_t  cur;
    logic [31:0] ad_o;
    logic        ad_oe;
    logic [3:0]  cbe_o;
    logic        cbe_oe;
    logic [3:0]  ctl_o;
    logic [3:0]  ctl_oe;
    logic [3:0]  gnt_o;
    logic [3:0]  gnt_oe;
    logic [3:0]  req_o;
    logic [3:0]  req_oe;
    logic [2:0]  tmo;
    logic        wr;
    logic        done;
    logic        abort;
    logic [31:0] rd_data;
    logic        tw_valid;
    logic [31:0] tw_data;
  } pcibp_agt_t;
  pcibp_agt_t q, d;
  logic idle_bus;

  always_comb
  begin
    d          = q;
    d.done     = 1'b0;
    d.abort    = 1'b0;
    d.tw_valid = 1'b0;
    idle_bus   = bus.transaction_frame_n & bus.initiator_ready_n;
    d.gnt_oe   = (i_mode == PCIBP_HOST_INT) ? 4'h0 : 4'h1;
    d.req_oe   = (i_mode == PCIBP_HOST_INT) ? 4'h1 << P_IDX : 4'h0;
    d.req_o    = ~({3'h0, i_m_valid && q.st == ST_IDLE} << P_IDX);
    // External arbiter: grant follows request, changed only on idle bus
    if (idle_bus && i_mode != PCIBP_HOST_INT)
      d.gnt_o = {3'h7, bus.bus_request_lines_n[0]};
    case (q.st)
      ST_IDLE:
      begin
        if (i_mode == PCIBP_HOST_INT && i_m_valid && idle_bus
            && !bus.bus_grant_lines_n[P_IDX])
        begin
          d.cur    = i_m_req;
          d.ad_o   = i_m_req.addr;
          d.ad_oe  = 1'b1;
          d.cbe_o  = i_m_req.cmd;
          d.cbe_oe = 1'b1;
          d.ctl_o[`PCIBP_C_FRAME]  = 1'b0;
          d.ctl_oe[`PCIBP_C_FRAME] = 1'b1;
          d.ctl_oe[`PCIBP_C_IRDY]  = 1'b1;
          d.tmo = '0;
          d.st  = ST_MADDR;
        end
        else if (!bus.transaction_frame_n
                 && pcibp_hit(bus.shared_addr_data_bus, P_BASE, P_MASK)
                 && bus.command_byte_lane_bus[3:1] == `PCIBP_CMD_MEM)
        begin
          d.wr = bus.command_byte_lane_bus[0];
          d.ctl_o[`PCIBP_C_TRDY]    = 1'b0;
          d.ctl_o[`PCIBP_C_DEVSEL]  = 1'b0;
          d.ctl_oe[`PCIBP_C_TRDY]   = 1'b1;
          d.ctl_oe[`PCIBP_C_DEVSEL] = 1'b1;
          d.ad_o  = i_t_rd_data;
          d.ad_oe = !bus.command_byte_lane_bus[0];
          d.st    = ST_TDATA;
        end
      end
      ST_MADDR:
      begin
        d.ctl_o[`PCIBP_C_FRAME] = 1'b1;
        d.ctl_o[`PCIBP_C_IRDY]  = 1'b0;
        d.cbe_o = q.cur.be_n;
        d.ad_o  = q.cur.data;
        d.ad_oe = q.cur.cmd[0];
        d.st    = ST_MDATA;
      end
      ST_MDATA:
      begin
        if (!bus.target_ready_n || (bus.target_claim_n && q.tmo == `PCIBP_CLAIM_TMO))
        begin
          d.done    = 1'b1;
          d.abort   = bus.target_ready_n;
          d.rd_data = bus.shared_addr_data_bus;
          d.ctl_o[`PCIBP_C_IRDY] = 1'b1;
          d.ad_oe  = 1'b0;
          d.cbe_oe = 1'b0;
          d.st     = ST_MTURN;
        end
        else if (bus.target_claim_n)
          d.tmo = q.tmo + 3'h1;
      end
      ST_MTURN:
      begin
        d.ctl_oe[`PCIBP_C_FRAME] = 1'b0;
        d.ctl_oe[`PCIBP_C_IRDY]  = 1'b0;
        d.st = ST_IDLE;
      end
      ST_TDATA:
      begin
        if (!bus.initiator_ready_n)
        begin
          d.tw_valid = q.wr;
          d.tw_data  = bus.shared_addr_data_bus;
          d.ad_o     = i_t_rd_data;
          if (bus.transaction_frame_n)
          begin
            d.ctl_o[`PCIBP_C_TRDY]   = 1'b1;
            d.ctl_o[`PCIBP_C_DEVSEL] = 1'b1;
            d.ad_oe = 1'b0;
            d.st    = ST_TTURN;
          end
        end
      end
      ST_TTURN:
      begin
        d.ctl_oe[`PCIBP_C_TRDY]   = 1'b0;
        d.ctl_oe[`PCIBP_C_DEVSEL] = 1'b0;
        d.st = ST_IDLE;
      end
      default:
        d.st = ST_IDLE;
    endcase
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_n)
    begin
      q       <= '0;
      q.ctl_o <= 4'hF;
      q.gnt_o <= 4'hF;
      q.req_o <= 4'hF;
    end
    else if (i_clk_en)
      q <= d;
  end

  assign bus.agt_ad_o   = q.ad_o;
  assign bus.agt_ad_oe  = q.ad_oe;
  assign bus.agt_cbe_o  = q.cbe_o;
  assign bus.agt_cbe_oe = q.cbe_oe;
  assign bus.agt_ctl_o  = q.ctl_o;
  assign bus.agt_ctl_oe = q.ctl_oe;
  assign bus.agt_gnt_o  = q.gnt_o;
  assign bus.agt_gnt_oe = q.gnt_oe;
  assign bus.agt_req_o  = q.req_o;
  assign bus.agt_req_oe = q.req_oe;
  assign o_m_done       = q.done;
  assign o_m_abort      = q.abort;
  assign o_m_rd_data    = q.rd_data;
  assign o_t_wr_valid   = q.tw_valid;
  assign o_t_wr_data    = q.tw_data;
endmodule
`default_nettype wire

// ==== verilog/pcibp_cfg.svh ====
// Constants of the shared address/data bus port: widths, pin slots,
// address windows and timeouts. Definitions only.
`ifndef PCIBP_CFG_SVH
`define PCIBP_CFG_SVH
`define PCIBP_AD_W       32
`define PCIBP_CBE_W      4
`define PCIBP_NLINE      4
`define PCIBP_FIFO_DEPTH 16
// Slots of the four control pins in the ctl vectors
`define PCIBP_C_FRAME    0
`define PCIBP_C_IRDY     1
`define PCIBP_C_TRDY     2
`define PCIBP_C_DEVSEL   3
// Memory read/write commands share these upper bits; bit 0 set is write
`define PCIBP_CMD_MEM    3'h3
`define PCIBP_DEV_BASE   32'h10000000
`define PCIBP_AGT_BASE   32'h20000000
`define PCIBP_WIN_MASK   32'hFFFF0000
// Cycles without a claim before the master gives up
`define PCIBP_CLAIM_TMO  3'h5
`endif

// ==== verilog/pcibp_pkg.sv ====
// Types shared by both ends of the bus port.
// Assumes pcibp_cfg.svh on the include path.
`default_nettype none
`include "pcibp_cfg.svh"
package pcibp_pkg;
  typedef enum logic [1:0] {PCIBP_HOST_INT, PCIBP_HOST_EXT, PCIBP_SAT} pcibp_mode_t;
  typedef enum logic [2:0] {ST_IDLE, ST_MADDR, ST_MDATA, ST_MTURN, ST_TDATA, ST_TTURN} pcibp_st_t;
  typedef struct packed {
    logic [3:0]  cmd;
    logic [3:0]  be_n;
    logic [31:0] addr;
    logic [31:0] data;
  } pcibp_req_t;
  function automatic logic pcibp_hit(input logic [31:0] a, input logic [31:0] base,
                                     input logic [31:0] mask);
    pcibp_hit = (a & mask) == (base & mask);
  endfunction
endpackage
`default_nettype wire

// ==== verilog/pcibp_if.sv ====
// Bus port wires between the device end and the far agent end.
// Each pin is driven as value plus enable; undriven pins pull high.
`timescale 1ns/1ps
`default_nettype none
`include "pcibp_cfg.svh"
interface pcibp_if;
  logic [31:0] dev_ad_o,  agt_ad_o,  shared_addr_data_bus;
  logic        dev_ad_oe, agt_ad_oe;
  logic [3:0]  dev_cbe_o, agt_cbe_o, command_byte_lane_bus;
  logic        dev_cbe_oe, agt_cbe_oe;
  logic [3:0]  dev_ctl_o, dev_ctl_oe, agt_ctl_o, agt_ctl_oe, ctl;
  logic [3:0]  dev_gnt_o, dev_gnt_oe, agt_gnt_o, agt_gnt_oe, bus_grant_lines_n;
  logic [3:0]  dev_req_o, dev_req_oe, agt_req_o, agt_req_oe, bus_request_lines_n;
  logic        transaction_frame_n, initiator_ready_n, target_ready_n, target_claim_n;

  assign shared_addr_data_bus  = dev_ad_oe ? dev_ad_o : agt_ad_oe ? agt_ad_o : '1;
  assign command_byte_lane_bus = dev_cbe_oe ? dev_cbe_o : agt_cbe_oe ? agt_cbe_o : '1;
  assign ctl = (dev_ctl_o & dev_ctl_oe) | (agt_ctl_o & agt_ctl_oe) | ~(dev_ctl_oe | agt_ctl_oe);
  assign bus_grant_lines_n = (dev_gnt_o & dev_gnt_oe) | (agt_gnt_o & agt_gnt_oe)
                             | ~(dev_gnt_oe | agt_gnt_oe);
  assign bus_request_lines_n = (dev_req_o & dev_req_oe) | (agt_req_o & agt_req_oe)
                               | ~(dev_req_oe | agt_req_oe);
  assign transaction_frame_n = ctl[`PCIBP_C_FRAME];
  assign initiator_ready_n   = ctl[`PCIBP_C_IRDY];
  assign target_ready_n      = ctl[`PCIBP_C_TRDY];
  assign target_claim_n      = ctl[`PCIBP_C_DEVSEL];

  modport dev (
    output dev_ad_o, dev_ad_oe, dev_cbe_o, dev_cbe_oe, dev_ctl_o, dev_ctl_oe,
    output dev_gnt_o, dev_gnt_oe, dev_req_o, dev_req_oe,
    input  shared_addr_data_bus, command_byte_lane_bus, bus_grant_lines_n,
    input  bus_request_lines_n, transaction_frame_n, initiator_ready_n,
    input  target_ready_n, target_claim_n
  );
  modport agt (
    output agt_ad_o, agt_ad_oe, agt_cbe_o, agt_cbe_oe, agt_ctl_o, agt_ctl_oe,
    output agt_gnt_o, agt_gnt_oe, agt_req_o, agt_req_oe,
    input  shared_addr_data_bus, command_byte_lane_bus, bus_grant_lines_n,
    input  bus_request_lines_n, transaction_frame_n, initiator_ready_n,
    input  target_ready_n, target_claim_n
  );
endinterface
`default_nettype wire

// ==== verilog/pcibp_dev.sv ====
// Device end of the bus port: master fed from a request FIFO, memory
// target, and grant/request line handling for the three grant modes.
// Assumes all bus parties run on i_sys_clk; pins arrive via pcibp_if.
`timescale 1ns/1ps
`default_nettype none
`include "pcibp_cfg.svh"

module pcibp_dev #(
  parameter logic [31:0] P_BASE  = `PCIBP_DEV_BASE,
  parameter logic [31:0] P_MASK  = `PCIBP_WIN_MASK,
  parameter int          P_DEPTH = `PCIBP_FIFO_DEPTH
) (
  // Clock and control
  input  wire logic               i_sys_clk,
  input  wire logic               i_rst_n,
  input  wire logic               i_clk_en,
  input  wire pcibp_pkg::pcibp_mode_t i_mode,
  // Master requests
  input  wire logic               i_m_valid,
  input  wire pcibp_pkg::pcibp_req_t i_m_req,
  output logic                    o_m_ready,
  output logic                    o_m_rd_valid,
  output logic [31:0]             o_m_rd_data,
  output logic                    o_m_abort,
  // Target side
  input  wire logic [31:0]        i_t_rd_data,
  output logic                    o_t_wr_valid,
  output logic [31:0]             o_t_wr_data,
  output logic [3:0]              o_t_wr_be,
  // Bus pins
  pcibp_if.dev                    bus
);
  import pcibp_pkg::*;

  typedef struct packed {
    pcibp_st_t   st;
    pcibp_req_t  cur;
    logic [31:0] ad_o;
    logic        ad_oe;
    logic [3:0]  cbe_o;
    logic        cbe_oe;
    logic [3:0]  ctl_o;
    logic [3:0]  ctl_oe;
    logic [3:0]  gnt_o;
    logic [3:0]  gnt_oe;
    logic [3:0]  req_o;
    logic [3:0]  req_oe;
    logic [1:0]  rr;
    logic [2:0]  tmo;
    logic        wr;
    logic        rd_valid;
    logic [31:0] rd_data;
    logic        abort;
    logic        tw_valid;
    logic [31:0] tw_data;
    logic [3:0]  tw_be;
  } pcibp_dev_t;
  pcibp_dev_t q, d;

  logic       f_vld, pop, idle_bus, start;
  pcibp_req_t f_head;
  logic [2:0] pk;

  // Round robin from current owner, so the owner keeps the bus while asking
  function automatic logic [2:0] pick(input logic [3:0] req_n, input logic [1:0] from);
    logic [1:0] k;
    pick = 3'h0;
    for (int i = 3; i >= 0; i--)
    begin
      k = from + 2'(i);
      if (!req_n[k])
        pick = {1'b1, k};
    end
  endfunction

  pcibp_fifo #(
    .W     ($bits(pcibp_req_t)),
    .DEPTH (P_DEPTH)
  ) u_fifo (
    .i_sys_clk   (i_sys_clk),
    .i_rst_n     (i_rst_n),
    .i_clk_en    (i_clk_en),
    .i_in_valid  (i_m_valid),
    .i_in_data   (i_m_req),
    .o_in_ready  (o_m_ready),
    .o_out_valid (f_vld),
    .o_out_data  (f_head),
    .i_out_ready (pop)
  );

  always_comb
  begin
    d          = q;
    pop        = 1'b0;
    d.rd_valid = 1'b0;
    d.abort    = 1'b0;
    d.tw_valid = 1'b0;
    idle_bus   = bus.transaction_frame_n & bus.initiator_ready_n;
    pk         = pick(bus.bus_request_lines_n, q.rr);
    if (i_mode == PCIBP_HOST_INT)
    begin
      d.gnt_oe = 4'hF;
      d.req_oe = 4'h0;
      // Device masters only while no agent asks; agents may starve it
      start    = f_vld && idle_bus && q.st == ST_IDLE && q.gnt_o == 4'hF && !pk[2];
    end
    else
    begin
      d.gnt_oe = 4'hE;
      d.gnt_o  = 4'hF;
      d.req_oe = 4'hF;
      d.req_o  = {3'h7, ~f_vld};
      start    = f_vld && idle_bus && q.st == ST_IDLE && !bus.bus_grant_lines_n[0];
    end
    // Single grant, changed only while idle
    if (i_mode == PCIBP_HOST_INT && idle_bus && q.st == ST_IDLE)
    begin
      d.gnt_o = pk[2] ? ~(4'h1 << pk[1:0]) : 4'hF;
      d.rr    = pk[2] ? pk[1:0] : q.rr;
    end
    case (q.st)
      ST_IDLE:
      begin
        if (start)
        begin
          pop    = 1'b1;
          d.cur  = f_head;
          d.ad_o = f_head.addr;
          d.ad_oe  = 1'b1;
          d.cbe_o  = f_head.cmd;
          d.cbe_oe = 1'b1;
          d.ctl_o[`PCIBP_C_FRAME]  = 1'b0;
          d.ctl_o[`PCIBP_C_IRDY]   = 1'b1;
          d.ctl_oe[`PCIBP_C_FRAME] = 1'b1;
          d.ctl_oe[`PCIBP_C_IRDY]  = 1'b1;
          d.tmo  = '0;
          d.st   = ST_MADDR;
        end
        // Claim decoded access, drive read data
        else if (!bus.transaction_frame_n
                 && pcibp_hit(bus.shared_addr_data_bus, P_BASE, P_MASK)
                 && bus.command_byte_lane_bus[3:1] == `PCIBP_CMD_MEM)
        begin
          d.wr = bus.command_byte_lane_bus[0];
          d.ctl_o[`PCIBP_C_TRDY]    = 1'b0;
          d.ctl_o[`PCIBP_C_DEVSEL]  = 1'b0;
          d.ctl_oe[`PCIBP_C_TRDY]   = 1'b1;
          d.ctl_oe[`PCIBP_C_DEVSEL] = 1'b1;
          d.ad_o  = i_t_rd_data;
          d.ad_oe = !bus.command_byte_lane_bus[0];
          d.st    = ST_TDATA;
        end
      end
      ST_MADDR:
      begin
        d.ctl_o[`PCIBP_C_FRAME] = 1'b1;
        d.ctl_o[`PCIBP_C_IRDY]  = 1'b0;
        d.cbe_o = q.cur.be_n;
        d.ad_o  = q.cur.data;
        d.ad_oe = q.cur.cmd[0];
        d.st    = ST_MDATA;
      end
      ST_MDATA:
      begin
        // Both ready low completes; no claim gives up, no hang
        if (!bus.target_ready_n || (bus.target_claim_n && q.tmo == `PCIBP_CLAIM_TMO))
        begin
          d.rd_valid = !q.cur.cmd[0] && !bus.target_ready_n;
          d.abort    = bus.target_ready_n;
          d.rd_data  = bus.target_ready_n ? q.rd_data : bus.shared_addr_data_bus;
          d.ctl_o[`PCIBP_C_IRDY] = 1'b1;
          d.ad_oe  = 1'b0;
          d.cbe_oe = 1'b0;
          d.st     = ST_MTURN;
        end
        else if (bus.target_claim_n)
          d.tmo = q.tmo + 3'h1;
      end
      ST_MTURN:
      begin
        d.ctl_oe[`PCIBP_C_FRAME] = 1'b0;
        d.ctl_oe[`PCIBP_C_IRDY]  = 1'b0;
        d.st = ST_IDLE;
      end
      ST_TDATA:
      begin
        // Word moves when initiator ready too
        if (!bus.initiator_ready_n)
        begin
          d.tw_valid = q.wr;
          d.tw_data  = bus.shared_addr_data_bus;
          d.tw_be    = ~bus.command_byte_lane_bus;
          d.ad_o     = i_t_rd_data;
          if (bus.transaction_frame_n)
          begin
            d.ctl_o[`PCIBP_C_TRDY]   = 1'b1;
            d.ctl_o[`PCIBP_C_DEVSEL] = 1'b1;
            d.ad_oe = 1'b0;
            d.st    = ST_TTURN;
          end
        end
      end
      ST_TTURN:
      begin
        d.ctl_oe[`PCIBP_C_TRDY]   = 1'b0;
        d.ctl_oe[`PCIBP_C_DEVSEL] = 1'b0;
        d.st = ST_IDLE;
      end
      default:
        d.st = ST_IDLE;
    endcase
  end

  // One clock for the whole port
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_n)
    begin
      q       <= '0;
      q.ctl_o <= 4'hF;
      q.gnt_o <= 4'hF;
      q.req_o <= 4'hF;
    end
    else if (i_clk_en)
      q <= d;
  end

  assign bus.dev_ad_o   = q.ad_o;
  assign bus.dev_ad_oe  = q.ad_oe;
  assign bus.dev_cbe_o  = q.cbe_o;
  assign bus.dev_cbe_oe = q.cbe_oe;
  assign bus.dev_ctl_o  = q.ctl_o;
  assign bus.dev_ctl_oe = q.ctl_oe;
  assign bus.dev_gnt_o  = q.gnt_o;
  assign bus.dev_gnt_oe = q.gnt_oe;
  assign bus.dev_req_o  = q.req_o;
  assign bus.dev_req_oe = q.req_oe;
  assign o_m_rd_valid   = q.rd_valid;
  assign o_m_rd_data    = q.rd_data;
  assign o_m_abort      = q.abort;
  assign o_t_wr_valid   = q.tw_valid;
  assign o_t_wr_data    = q.tw_data;
  assign o_t_wr_be      = q.tw_be;
endmodule
`default_nettype wire

// ==== dv/pcibp_bus_asserts.sv ====
// Checks on the resolved wires of the bus port.
// Assumes one clock and the signal names of pcibp_if.
`timescale 1ns/1ps
`default_nettype none
module pcibp_bus_asserts (
  // Clock, reset, mode
  input  wire logic                   i_sys_clk,
  input  wire logic                   i_rst_n,
  input  wire pcibp_pkg::pcibp_mode_t i_mode,
  // Resolved wires
  input  wire logic [31:0]            shared_addr_data_bus,
  input  wire logic [3:0]             bus_grant_lines_n,
  input  wire logic [3:0]             bus_request_lines_n,
  input  wire logic                   transaction_frame_n,
  input  wire logic                   initiator_ready_n,
  input  wire logic                   target_ready_n,
  input  wire logic                   target_claim_n
);
  import pcibp_pkg::*;
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);

  a_one_grant: assert property (
    i_mode == PCIBP_HOST_INT |-> $countones(~bus_grant_lines_n) <= 1)
    else $error("more than one grant low");
  a_grant_idle_only: assert property (
    i_mode == PCIBP_HOST_INT && $past(i_mode) == PCIBP_HOST_INT
    && bus_grant_lines_n != $past(bus_grant_lines_n)
    |-> $past(transaction_frame_n) && $past(initiator_ready_n))
    else $error("grant moved on busy bus");
  a_grant_needs_req: assert property (
    i_mode == PCIBP_HOST_INT && $fell(bus_grant_lines_n[0])
    |-> $past(bus_request_lines_n[0]) == 1'b0)
    else $error("grant without request");
  a_unused_grants_high: assert property (
    i_mode != PCIBP_HOST_INT && $past(i_mode) == i_mode |-> bus_grant_lines_n[3:1] == 3'h7)
    else $error("unused grant line low");
  a_ext_grant_first: assert property (
    i_mode != PCIBP_HOST_INT && $fell(transaction_frame_n)
    |-> $past(bus_grant_lines_n[0]) == 1'b0)
    else $error("frame without grant");
  a_frame_last_phase: assert property (
    $fell(transaction_frame_n) |=> transaction_frame_n && !initiator_ready_n)
    else $error("frame not ended at data phase");
  a_irdy_bounded: assert property (
    $fell(transaction_frame_n) |=> !initiator_ready_n ##[1:8] initiator_ready_n)
    else $error("initiator ready not released");
  a_claim_decoded: assert property (
    $fell(target_claim_n) |-> $past(transaction_frame_n) == 1'b0
    && $past(shared_addr_data_bus[31:16]) inside {16'h1000, 16'h2000})
    else $error("claim without decoded address");
  a_trdy_claimed: assert property (
    !target_ready_n |-> !target_claim_n)
    else $error("target ready without claim");
  a_data_done: assert property (
    !initiator_ready_n && !target_ready_n |=> initiator_ready_n)
    else $error("data phase not finished");
endmodule
`default_nettype wire

// ==== dv/pcibp_bench.sv ====
// Self-checking bench: device end and agent end joined by pcibp_if.
// Assumes the design files and pcibp_cfg.svh on the include path.
`timescale 1ns/1ps
`default_nettype none
`include "pcibp_cfg.svh"
`define CHK(g, e) \
  begin \
    n_compared++; \
    if ((g) !== (e)) \
    begin \
      err_count++; \
      $display("MISMATCH %0t: got %h want %h", $time, (g), (e)); \
    end \
  end
module pcibp_bench;
  import pcibp_pkg::*;
  logic        i_sys_clk, i_rst_n, m_valid, a_valid, agt_rd, m_ready;
  logic        d_rdv, d_abort, d_twv, a_done, a_abort, a_twv;
  logic [31:0] d_trd, a_trd, d_rdd, d_twd, a_rdd, a_twd;
  logic [3:0]  d_twbe;
  pcibp_mode_t mode;
  pcibp_req_t  m_req, a_req;
  logic [39:0] exp_q[$];
  int          err_count = 0, n_compared = 0, cyc = 0, n_push;

  pcibp_if u_if();
  pcibp_dev pcibp_dev_i (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_clk_en(1'b1),
    .i_mode(mode), .i_m_valid(m_valid), .i_m_req(m_req), .o_m_ready(m_ready),
    .o_m_rd_valid(d_rdv), .o_m_rd_data(d_rdd), .o_m_abort(d_abort), .i_t_rd_data(d_trd),
    .o_t_wr_valid(d_twv), .o_t_wr_data(d_twd), .o_t_wr_be(d_twbe), .bus(u_if));
  pcibp_agent pcibp_agent_i (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_clk_en(1'b1),
    .i_mode(mode), .i_m_valid(a_valid), .i_m_req(a_req), .o_m_done(a_done),
    .o_m_abort(a_abort), .o_m_rd_data(a_rdd), .i_t_rd_data(a_trd), .o_t_wr_valid(a_twv),
    .o_t_wr_data(a_twd), .bus(u_if));
  pcibp_bus_asserts chk_i (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_mode(mode),
    .shared_addr_data_bus(u_if.shared_addr_data_bus),
    .bus_grant_lines_n(u_if.bus_grant_lines_n),
    .bus_request_lines_n(u_if.bus_request_lines_n),
    .transaction_frame_n(u_if.transaction_frame_n),
    .initiator_ready_n(u_if.initiator_ready_n), .target_ready_n(u_if.target_ready_n),
    .target_claim_n(u_if.target_claim_n));

  initial
  begin
    i_sys_clk = 1'b0;
    forever #25 i_sys_clk = ~i_sys_clk;
  end

  task automatic test_done();
    if (err_count == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic note(input logic [39:0] got);
    logic [39:0] want;
    if (exp_q.size() == 0)
    begin
      err_count++;
      $display("MISMATCH %0t: unexpected result %h", $time, got);
    end
    else
    begin
      want = exp_q.pop_front();
      `CHK(got, want)
    end
  endtask

  // Outputs are settled at the falling edge
  always @(negedge i_sys_clk)
  begin
    if (a_twv) note({8'h00, a_twd});
    if (d_rdv) note({8'h10, d_rdd});
    if (d_twv) note({4'h2, d_twbe, d_twd});
    if (a_done && !a_abort && agt_rd) note({8'h30, a_rdd});
    if (d_abort) note(40'h4000000000);
  end

  always @(posedge i_sys_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 6000)
    begin
      err_count++;
      test_done();
    end
  end

  task automatic dev_op(input logic [3:0] cmd, input logic [31:0] a);
    logic [31:0] d;
    logic [3:0]  be;
    d = $urandom;
    be = 4'($urandom);
    @(posedge i_sys_clk);
    m_valid <= 1'b1;
    m_req <= '{cmd, be, a, d};
    if (a[31:16] != 16'h2000)
      exp_q.push_back(40'h4000000000);
    else if (cmd[0])
      exp_q.push_back({8'h00, d});
    else
      exp_q.push_back({8'h10, a_trd});
    @(negedge i_sys_clk);
    while (!m_ready) @(negedge i_sys_clk);
    @(posedge i_sys_clk);
    m_valid <= 1'b0;
  endtask

  task automatic agt_op(input logic rd, input logic [31:0] a);
    logic [31:0] d;
    logic [3:0]  be;
    d = $urandom;
    be = 4'($urandom);
    @(posedge i_sys_clk);
    a_valid <= 1'b1;
    agt_rd <= rd;
    a_req <= '{rd ? 4'h6 : 4'h7, be, a, d};
    if (rd)
      exp_q.push_back({8'h30, d_trd});
    else
      exp_q.push_back({4'h2, ~be, d});
    @(negedge i_sys_clk);
    while (!a_done) @(negedge i_sys_clk);
    @(posedge i_sys_clk);
    a_valid <= 1'b0;
  endtask

  task automatic settle();
    for (int i = 0; i < 600 && exp_q.size() != 0; i++)
      @(posedge i_sys_clk);
    repeat (6) @(posedge i_sys_clk);
  endtask

  initial
  begin
    i_rst_n = 1'b0;
    m_valid = 1'b0;
    a_valid = 1'b0;
    agt_rd = 1'b0;
    m_req = '0;
    a_req = '0;
    mode = PCIBP_HOST_EXT;
    void'($urandom(32'h4990));
    d_trd = $urandom;
    a_trd = $urandom;
    repeat (8) @(posedge i_sys_clk);
    i_rst_n <= 1'b1;
    for (int k = 0; k < 2; k++)
    begin
      @(posedge i_sys_clk);
      mode <= k ? PCIBP_SAT : PCIBP_HOST_EXT;
      dev_op(4'h7, `PCIBP_AGT_BASE | 32'h10);
      dev_op(4'h6, `PCIBP_AGT_BASE | 32'h20);
      dev_op(4'h7, 32'h30000000);
      settle();
    end
    @(posedge i_sys_clk);
    mode <= PCIBP_HOST_INT;
    repeat (3) @(posedge i_sys_clk);
    agt_op(1'b0, `PCIBP_DEV_BASE | 32'h8);
    agt_op(1'b1, `PCIBP_DEV_BASE | 32'hC);
    dev_op(4'h6, `PCIBP_AGT_BASE);
    settle();
    // Agent hogs the bus with aborting reads so the buffer fills
    @(posedge i_sys_clk);
    a_valid <= 1'b1;
    agt_rd <= 1'b0;
    a_req <= '{4'h6, 4'h0, 32'h30000000, 32'h0};
    repeat (4) @(posedge i_sys_clk);
    m_valid <= 1'b1;
    m_req <= '{4'h7, 4'h0, `PCIBP_AGT_BASE, $urandom};
    n_push = 0;
    for (int i = 1; i < 40; i++)
    begin
      @(negedge i_sys_clk);
      if (!m_ready) break;
      exp_q.push_back({8'h00, m_req.data});
      n_push++;
      @(posedge i_sys_clk);
      m_req <= '{4'h7, 4'($urandom), `PCIBP_AGT_BASE | 32'(i * 4), $urandom};
    end
    @(posedge i_sys_clk);
    m_valid <= 1'b0;
    a_valid <= 1'b0;
    `CHK(n_push >= 16, 1'b1)
    settle();
    `CHK(exp_q.size(), 0)
    test_done();
  end
endmodule
`default_nettype wire
